// ===== design/cse_pkg.sv
/*
 * Shared constants and types of the codec slot enable and status block.
 * Assumes a 16-bit plain register port with a 4-bit word address.
 */
package cse_pkg;
    localparam int DATA_W = 16;
    localparam int ADDR_W = 4;
    localparam int SLOT_W = 4;
    localparam int BUF_DEPTH = 4;

    // Register addresses
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_STATUS = 4'h1;
    localparam logic [3:0] ADDR_RX_SLOT_EN = 4'h2;
    localparam logic [3:0] ADDR_TX_SLOT_EN = 4'h3;
    localparam logic [3:0] ADDR_TX_DATA = 4'h4;
    localparam logic [3:0] ADDR_RX_DATA = 4'h5;
    localparam logic [3:0] ADDR_IRQ_STAT = 4'h6;
    localparam logic [3:0] ADDR_IRQ_CLR = 4'h7;
    localparam logic [3:0] ADDR_IRQ_EN = 4'h8;

    // Control fields
    localparam int CTRL_ENABLE_BIT = 0;
    localparam int CTRL_IDLE_MODE_BIT = 1;

    // Status fields, also the layout of the interrupt registers
    localparam int ST_TX_EMPTY_BIT = 0;
    localparam int ST_TX_UNDERFLOW_BIT = 1;
    localparam int ST_RX_FULL_BIT = 2;
    localparam int ST_RX_OVERFLOW_BIT = 3;
    localparam int ST_SLOT_LSB = 8;
    localparam int IRQ_W = 4;

    // Reset values and the last bit index of a slot
    localparam logic [15:0] SLOT_EN_RESET = 16'h0000;
    localparam logic [1:0] CTRL_RESET = 2'h0;
    localparam logic [3:0] IRQ_RESET = 4'h0;
    localparam logic [3:0] LAST_BIT = 4'hf;

    typedef struct packed {
        logic bclk;
        logic fsync;
        logic sdi;
    } cse_link_in_s;

    typedef struct packed {
        logic sdo;
        logic sdo_oe;
    } cse_link_out_s;
endpackage : cse_pkg

// ===== design/cse_sync.sv
/*
 * Three-stage input synchroniser with agreement filter.
 * Assumes asynchronous inputs; output changes when stages two and three agree.
 */
`timescale 1ns/1ps
module cse_sync #(
    parameter int W = 3
) (
    input wire logic i_clk_sys,
    input wire logic i_rstn,
    input wire logic [W-1:0] i_async,
    output logic [W-1:0] o_sync
);
    logic [W-1:0] s1_ff;
    logic [W-1:0] s2_ff;
    logic [W-1:0] s3_ff;
    logic [W-1:0] out_ff;
    logic [W-1:0] agree;
    logic [W-1:0] nxt_out;

    assign agree = ~(s2_ff ^ s3_ff);
    assign nxt_out = (agree & s3_ff) | (~agree & out_ff);
    assign o_sync = out_ff;

    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            s1_ff <= '0;
            s2_ff <= '0;
            s3_ff <= '0;
            out_ff <= '0;
        end else begin
            s1_ff <= i_async;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            out_ff <= nxt_out;
        end
    end
endmodule : cse_sync

// ===== design/cse_top.sv
/*
 * Slot-enabled framed serial audio port with receive and transmit word
 * buffers, status flags, slot enables and a level interrupt.
 * Assumes bit clock and frame sync come from the codec; data is sampled on
 * falling bit clock and driven after rising bit clock; 16-bit slots.
 */
// The address-and-strobe port and the register addresses were left to the implementer.
// Notes on behaviour
// - Receive overflow flag set on dropped word
// - Receive full flag while unread words wait
// - Transmit underflow flag set on empty load
// - Transmit empty flag while no word queued
// - Receive enable bit n selects slot n
// - Enabled receive slot captures into buffer
// - Disabled receive slot is discarded
// - Transmit enable bit n governs slot n
// - Enabled transmit slot shifts next word out
// - Disabled transmit slot floats or drives low
// - Sixteen-bit shifts, most significant bit first
// - Idle mode chooses float or low
`timescale 1ns/1ps
module cse_top #(
    parameter int DEPTH = cse_pkg::BUF_DEPTH
) (
    input wire logic i_clk_sys,
    input wire logic i_rstn,
    input wire logic [cse_pkg::ADDR_W-1:0] i_addr,
    input wire logic [cse_pkg::DATA_W-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [cse_pkg::DATA_W-1:0] o_rdata,
    input cse_pkg::cse_link_in_s i_link,
    output cse_pkg::cse_link_out_s o_link,
    output logic o_irq
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);
    localparam logic [CW-1:0] CNT_ONE = CW'(1);

    function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
        ptr_inc = (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
    endfunction : ptr_inc

    function automatic logic [CW-1:0] cnt_next(input logic [CW-1:0] c, input logic up, input logic dn);
        cnt_next = c + CW'(up) - CW'(dn);
    endfunction : cnt_next

    function automatic logic reg_hit(input logic [cse_pkg::ADDR_W-1:0] a, input logic [cse_pkg::ADDR_W-1:0] t);
        reg_hit = (a == t);
    endfunction : reg_hit

    cse_pkg::cse_link_in_s link_s;

    cse_sync #(.W(3)) u_sync (
        .i_clk_sys(i_clk_sys),
        .i_rstn(i_rstn),
        .i_async(i_link),
        .o_sync(link_s)
    );

    // Registers
    logic [1:0] ctrl_ff;
    logic [15:0] rx_slot_en_ff;
    logic [15:0] tx_slot_en_ff;
    logic [cse_pkg::IRQ_W-1:0] irq_stat_ff;
    logic [cse_pkg::IRQ_W-1:0] irq_en_ff;
    logic [15:0] rdata_ff;

    // Link state
    logic bclk_q_ff;
    logic fs_q_ff;
    logic run_ff;
    logic [3:0] bit_ff;
    logic [3:0] slot_ff;
    logic [15:0] tx_shift_ff;
    logic [15:0] rx_shift_ff;
    logic tx_act_ff;

    // Buffers
    logic [15:0] tx_buf_ff [DEPTH];
    logic [15:0] rx_buf_ff [DEPTH];
    logic [PW-1:0] tx_wp_ff;
    logic [PW-1:0] tx_rp_ff;
    logic [CW-1:0] tx_cnt_ff;
    logic [PW-1:0] rx_wp_ff;
    logic [PW-1:0] rx_rp_ff;
    logic [CW-1:0] rx_cnt_ff;
    logic ovf_ff;
    logic unf_ff;

    // Decode
    wire en = ctrl_ff[cse_pkg::CTRL_ENABLE_BIT];
    wire idle_float = ctrl_ff[cse_pkg::CTRL_IDLE_MODE_BIT];
    wire wr_ctrl = i_wr && reg_hit(i_addr, cse_pkg::ADDR_CTRL);
    wire wr_rx_en = i_wr && reg_hit(i_addr, cse_pkg::ADDR_RX_SLOT_EN);
    wire wr_tx_en = i_wr && reg_hit(i_addr, cse_pkg::ADDR_TX_SLOT_EN);
    wire wr_tx_data = i_wr && reg_hit(i_addr, cse_pkg::ADDR_TX_DATA);
    wire wr_irq_clr = i_wr && reg_hit(i_addr, cse_pkg::ADDR_IRQ_CLR);
    wire wr_irq_en = i_wr && reg_hit(i_addr, cse_pkg::ADDR_IRQ_EN);
    wire rd_rx_data = i_rd && reg_hit(i_addr, cse_pkg::ADDR_RX_DATA);

    // Bit clock edges and frame start
    wire bclk_rise = en && link_s.bclk && !bclk_q_ff;
    wire bclk_fall = en && !link_s.bclk && bclk_q_ff;
    wire frame_start = bclk_rise && link_s.fsync && !fs_q_ff;
    wire word_end_rise = bclk_rise && run_ff && (bit_ff == cse_pkg::LAST_BIT);
    wire word_start = frame_start || word_end_rise;
    wire [3:0] nxt_bit = frame_start ? 4'h0 : bit_ff + 4'h1;
    wire [3:0] slot_step = word_end_rise ? slot_ff + 4'h1 : slot_ff;
    wire [3:0] nxt_slot = frame_start ? 4'h0 : slot_step;

    // Transmit side
    wire tx_have = (tx_cnt_ff != '0);
    wire tx_full = (tx_cnt_ff == CNT_FULL);
    wire tx_slot_on = tx_slot_en_ff[nxt_slot];
    wire tx_load = word_start && tx_slot_on;
    wire tx_pop = tx_load && tx_have;
    wire unf_evt = tx_load && !tx_have;
    wire tx_push = en && wr_tx_data && !tx_full;
    wire [15:0] tx_word = tx_have ? tx_buf_ff[tx_rp_ff] : 16'h0000;
    wire tx_drain_evt = tx_pop && !tx_push && (tx_cnt_ff == CNT_ONE);

    // Receive side
    wire [15:0] rx_word = {rx_shift_ff[14:0], link_s.sdi};
    wire rx_word_done = bclk_fall && run_ff && (bit_ff == cse_pkg::LAST_BIT);
    wire rx_slot_on = rx_slot_en_ff[slot_ff];
    wire rx_capture = rx_word_done && rx_slot_on;
    wire rx_have = (rx_cnt_ff != '0);
    wire rx_full = (rx_cnt_ff == CNT_FULL);
    wire rx_pop = en && rd_rx_data && rx_have;
    wire rx_push = rx_capture && (!rx_full || rx_pop);
    wire ovf_evt = rx_capture && rx_full && !rx_pop;

    // Status view
    logic [3:0] status_flags;
    logic [cse_pkg::IRQ_W-1:0] irq_evt;
    assign status_flags[cse_pkg::ST_RX_OVERFLOW_BIT] = ovf_ff;
    assign status_flags[cse_pkg::ST_RX_FULL_BIT] = rx_have;
    assign status_flags[cse_pkg::ST_TX_UNDERFLOW_BIT] = unf_ff;
    assign status_flags[cse_pkg::ST_TX_EMPTY_BIT] = !tx_have;
    assign irq_evt[cse_pkg::ST_RX_OVERFLOW_BIT] = ovf_evt;
    assign irq_evt[cse_pkg::ST_RX_FULL_BIT] = rx_push;
    assign irq_evt[cse_pkg::ST_TX_UNDERFLOW_BIT] = unf_evt;
    assign irq_evt[cse_pkg::ST_TX_EMPTY_BIT] = tx_drain_evt;
    wire [15:0] status_word = (16'(slot_ff) << cse_pkg::ST_SLOT_LSB) | 16'(status_flags);
    wire [cse_pkg::IRQ_W-1:0] irq_clr = wr_irq_clr ? i_wdata[cse_pkg::IRQ_W-1:0] : '0;

    // Read mux
    logic [15:0] rd_mux;
    always_comb begin
        case (i_addr)
            cse_pkg::ADDR_CTRL: rd_mux = {14'h0000, ctrl_ff};
            cse_pkg::ADDR_STATUS: rd_mux = status_word;
            cse_pkg::ADDR_RX_SLOT_EN: rd_mux = rx_slot_en_ff;
            cse_pkg::ADDR_TX_SLOT_EN: rd_mux = tx_slot_en_ff;
            cse_pkg::ADDR_RX_DATA: rd_mux = rx_have ? rx_buf_ff[rx_rp_ff] : 16'h0000;
            cse_pkg::ADDR_IRQ_STAT: rd_mux = {12'h000, irq_stat_ff};
            cse_pkg::ADDR_IRQ_EN: rd_mux = {12'h000, irq_en_ff};
            default: rd_mux = 16'h0000;
        endcase
    end

    // Software registers
    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            ctrl_ff <= cse_pkg::CTRL_RESET;
            rx_slot_en_ff <= cse_pkg::SLOT_EN_RESET;
            tx_slot_en_ff <= cse_pkg::SLOT_EN_RESET;
            irq_en_ff <= cse_pkg::IRQ_RESET;
            rdata_ff <= 16'h0000;
        end else begin
            if (wr_ctrl) begin
                ctrl_ff <= i_wdata[1:0];
            end
            if (wr_rx_en) begin
                rx_slot_en_ff <= i_wdata;
            end
            if (wr_tx_en) begin
                tx_slot_en_ff <= i_wdata;
            end
            if (wr_irq_en) begin
                irq_en_ff <= i_wdata[cse_pkg::IRQ_W-1:0];
            end
            rdata_ff <= i_rd ? rd_mux : 16'h0000;
        end
    end

    // Sticky interrupt status, set wins over clear
    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            irq_stat_ff <= cse_pkg::IRQ_RESET;
        end else begin
            irq_stat_ff <= (irq_stat_ff & ~irq_clr) | irq_evt;
        end
    end

    // Bit clock framing
    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn || !en) begin
            bclk_q_ff <= 1'b0;
            fs_q_ff <= 1'b0;
            run_ff <= 1'b0;
            bit_ff <= 4'h0;
            slot_ff <= 4'h0;
        end else begin
            bclk_q_ff <= link_s.bclk;
            if (bclk_rise) begin
                fs_q_ff <= link_s.fsync;
            end
            if (frame_start) begin
                run_ff <= 1'b1;
            end
            if (bclk_rise && (run_ff || frame_start)) begin
                bit_ff <= nxt_bit;
                slot_ff <= nxt_slot;
            end
        end
    end

    // Serial shifters
    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn || !en) begin
            tx_shift_ff <= 16'h0000;
            tx_act_ff <= 1'b0;
            rx_shift_ff <= 16'h0000;
        end else begin
            if (word_start) begin
                tx_shift_ff <= tx_load ? tx_word : 16'h0000;
                tx_act_ff <= tx_slot_on;
            end else if (bclk_rise && run_ff) begin
                tx_shift_ff <= {tx_shift_ff[14:0], 1'b0};
            end
            if (bclk_fall && run_ff) begin
                rx_shift_ff <= rx_word;
            end
        end
    end

    // Transmit buffer
    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn || !en) begin
            tx_wp_ff <= '0;
            tx_rp_ff <= '0;
            tx_cnt_ff <= '0;
        end else begin
            if (tx_push) begin
                tx_wp_ff <= ptr_inc(tx_wp_ff);
            end
            if (tx_pop) begin
                tx_rp_ff <= ptr_inc(tx_rp_ff);
            end
            tx_cnt_ff <= cnt_next(tx_cnt_ff, tx_push, tx_pop);
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (tx_push) begin
            tx_buf_ff[tx_wp_ff] <= i_wdata;
        end
        if (rx_push) begin
            rx_buf_ff[rx_wp_ff] <= rx_word;
        end
    end

    // Receive buffer
    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn || !en) begin
            rx_wp_ff <= '0;
            rx_rp_ff <= '0;
            rx_cnt_ff <= '0;
        end else begin
            if (rx_push) begin
                rx_wp_ff <= ptr_inc(rx_wp_ff);
            end
            if (rx_pop) begin
                rx_rp_ff <= ptr_inc(rx_rp_ff);
            end
            rx_cnt_ff <= cnt_next(rx_cnt_ff, rx_push, rx_pop);
        end
    end

    // Error flags held until serviced or disabled
    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn || !en) begin
            ovf_ff <= 1'b0;
            unf_ff <= 1'b0;
        end else begin
            ovf_ff <= ovf_evt || (ovf_ff && !rx_pop);
            unf_ff <= unf_evt || (unf_ff && !tx_push);
        end
    end

    // Outputs
    assign o_rdata = rdata_ff;
    assign o_irq = |(irq_stat_ff & irq_en_ff);
    assign o_link.sdo = tx_act_ff && tx_shift_ff[15];
    assign o_link.sdo_oe = tx_act_ff || (en && !idle_float);
endmodule : cse_top

// ===== test/cse_checker.sv
/* Port checker for cse_top.
   Assumes the package register map; bound at the foot of this file. */
`timescale 1ns/1ps
module cse_checker #(
    parameter int DEPTH = 4
) (
    input wire logic i_clk_sys,
    input wire logic i_rstn,
    input wire logic [3:0] i_addr,
    input wire logic [15:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [15:0] o_rdata,
    input cse_pkg::cse_link_in_s i_link,
    input cse_pkg::cse_link_out_s o_link,
    input wire logic o_irq
);
    logic [15:0] rx_ff;
    logic [15:0] tx_ff;
    logic [3:0] ie_ff;
    logic en_ff;
    logic txw_ff;
    logic lnk_ff;
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_rstn);
    // Shadow copies of written registers, a transmit write flag and a bit clock seen flag
    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            {rx_ff, tx_ff, ie_ff, en_ff, txw_ff, lnk_ff} <= '0;
        end else begin
            if (i_wr && i_addr == cse_pkg::ADDR_RX_SLOT_EN) rx_ff <= i_wdata;
            if (i_wr && i_addr == cse_pkg::ADDR_TX_SLOT_EN) tx_ff <= i_wdata;
            if (i_wr && i_addr == cse_pkg::ADDR_IRQ_EN) ie_ff <= i_wdata[3:0];
            if (i_wr && i_addr == cse_pkg::ADDR_CTRL) en_ff <= i_wdata[0];
            if (i_wr && i_addr == cse_pkg::ADDR_TX_DATA) txw_ff <= 1'b1;
            lnk_ff <= lnk_ff | i_link.bclk;
        end
    end
    AST_RDATA_IDLE: assert property (!$past(i_rd) |-> o_rdata == 16'h0000)
        else $error("read data not zero outside read cycle");
    AST_RX_EN_BACK: assert property (i_rd && i_addr == cse_pkg::ADDR_RX_SLOT_EN |=> o_rdata == $past(rx_ff))
        else $error("receive slot enables read back wrong");
    AST_TX_EN_BACK: assert property (i_rd && i_addr == cse_pkg::ADDR_TX_SLOT_EN |=> o_rdata == $past(tx_ff))
        else $error("transmit slot enables read back wrong");
    AST_STAT_RSVD: assert property (i_rd && i_addr == cse_pkg::ADDR_STATUS |=> o_rdata[15:12] == 4'h0 && o_rdata[7:4] == 4'h0)
        else $error("status unused bits not zero");
    AST_STAT_IDLE: assert property (i_rd && i_addr == cse_pkg::ADDR_STATUS && !lnk_ff |=> o_rdata[11:8] == 4'h0 && o_rdata[3:2] == 2'h0)
        else $error("status shows traffic before any frame");
    AST_TX_EMPTY: assert property (i_rd && i_addr == cse_pkg::ADDR_STATUS && !txw_ff |=> o_rdata[0])
        else $error("transmit empty flag low with nothing written");
    AST_OE_OFF: assert property ((!en_ff) [*3] |-> !o_link.sdo_oe)
        else $error("data output driven while disabled");
    AST_IRQ_MASK: assert property (ie_ff == 4'h0 && $past(ie_ff) == 4'h0 |-> !o_irq)
        else $error("interrupt high with all sources masked");
    cover property (o_irq);
    cover property (o_link.sdo_oe && o_link.sdo);
    cover property (i_rd && i_addr == cse_pkg::ADDR_RX_DATA ##1 o_rdata != 16'h0000);
endmodule : cse_checker
bind cse_top cse_checker #(.DEPTH(DEPTH)) i_chk (.i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_link(i_link), .o_link(o_link),
    .o_irq(o_irq));

// ===== test/cse_codec_model.sv
/* Codec model: bit clock, frame sync, serial input and output capture.
   Assumes a 64 ns bit clock that stands low between frames. */
`timescale 1ns/1ps
module cse_codec_model (
    output logic o_bclk,
    output logic o_fsync,
    output logic o_sdi,
    input wire logic i_sdo,
    input wire logic i_sdo_oe
);
    logic [15:0] src [16];
    logic [15:0] got [16];
    logic oe [16];
    initial begin
        o_bclk = 1'b0;
        o_fsync = 1'b0;
        o_sdi = 1'b1;
    end
    // One frame of n slots, most significant bit first
    task automatic frame(input int n);
        for (int s = 0; s < n; s++) begin
            for (int b = 15; b >= 0; b--) begin
                o_fsync = (s == 0 && b == 15);
                o_sdi = src[s][b];
                o_bclk = 1'b1;
                #32 o_bclk = 1'b0;
                #31 got[s][b] = i_sdo;
                oe[s] = i_sdo_oe;
                #1;
            end
        end
        o_fsync = 1'b0;
        o_sdi = ~o_sdi;
    endtask : frame
endmodule : cse_codec_model

// ===== test/tb.sv
/* Self-checking bench for cse_top with a codec model.
   Assumes 200 MHz clock and the package register map. */
`timescale 1ns/1ps
module tb;
    logic i_clk_sys = 1'b0;
    logic i_rstn = 1'b0;
    logic [3:0] i_addr = 4'h0;
    logic [15:0] i_wdata = 16'h0000;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [15:0] o_rdata;
    wire cse_pkg::cse_link_in_s i_link;
    cse_pkg::cse_link_out_s o_link;
    logic o_irq;
    int err_total = 0;
    int check_count = 0;
    logic [31:0] seed = 32'hdedbe5c0;
    logic [15:0] rx_en;
    logic [15:0] tx_en;
    logic [15:0] rd_v;
    logic idle;
    logic ovf;
    logic unf;
    logic [3:0] slot_now = 4'h0;
    logic [15:0] rxq [$];
    logic [15:0] txq [$];
    logic [15:0] exp_tx [16];
    logic exp_oe [16];
    always #2.5 i_clk_sys = ~i_clk_sys;
    cse_codec_model i_codec (.o_bclk(i_link.bclk), .o_fsync(i_link.fsync), .o_sdi(i_link.sdi),
        .i_sdo(o_link.sdo), .i_sdo_oe(o_link.sdo_oe));
    cse_top #(.DEPTH(4)) i_dut (.i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_link(i_link), .o_link(o_link), .o_irq(o_irq));
    function automatic logic [15:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[15:0];
    endfunction : rnd
    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge i_clk_sys);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk_sys);
        i_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a);
        @(posedge i_clk_sys);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk_sys);
        i_rd <= 1'b0;
        #1 rd_v = o_rdata;
    endtask : rd
    task automatic chk_status();
        rd(cse_pkg::ADDR_STATUS);
        chk("status", rd_v, {4'h0, slot_now, 4'h0, ovf, (rxq.size() > 0), unf, (txq.size() == 0)});
    endtask : chk_status
    // Model update, then one frame on the link
    task automatic frame(input int n);
        for (int s = 0; s < n; s++) begin
            i_codec.src[s] = rnd();
            exp_oe[s] = tx_en[s] | ~idle;
            exp_tx[s] = 16'h0000;
            if (rx_en[s] && rxq.size() < 4) rxq.push_back(i_codec.src[s]);
            else if (rx_en[s]) ovf = 1'b1;
            if (tx_en[s] && txq.size() > 0) exp_tx[s] = txq.pop_front();
            else if (tx_en[s]) unf = 1'b1;
        end
        #7 i_codec.frame(n);
        slot_now = 4'(n - 1);
        #200;
        for (int s = 0; s < n; s++) begin
            chk("sdo_oe", {15'h0000, i_codec.oe[s]}, {15'h0000, exp_oe[s]});
            if (exp_oe[s]) chk("sdo", i_codec.got[s], exp_tx[s]);
        end
    endtask : frame
    task automatic drain();
        while (rxq.size() > 0) begin
            rd(cse_pkg::ADDR_RX_DATA);
            chk("rx_word", rd_v, rxq.pop_front());
            ovf = 1'b0;
        end
    endtask : drain
    task automatic set_slots(input logic [15:0] r, input logic [15:0] t);
        rx_en = r;
        tx_en = t;
        wr(cse_pkg::ADDR_RX_SLOT_EN, r);
        wr(cse_pkg::ADDR_TX_SLOT_EN, t);
        rd(cse_pkg::ADDR_RX_SLOT_EN);
        chk("rx_en", rd_v, r);
        rd(cse_pkg::ADDR_TX_SLOT_EN);
        chk("tx_en", rd_v, t);
    endtask : set_slots
    task automatic finish_test();
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : finish_test
    initial begin
        #100000;
        err_total++;
        finish_test();
    end
    initial begin
        ovf = 1'b0;
        unf = 1'b0;
        idle = 1'b1;
        repeat (10) @(posedge i_clk_sys);
        i_rstn <= 1'b1;
        set_slots(16'h0000, 16'h0000);
        rd(4'hf);
        chk("unmapped", rd_v, 16'h0000);
        chk_status();
        wr(cse_pkg::ADDR_CTRL, 16'h0003);
        wr(cse_pkg::ADDR_IRQ_EN, 16'h000f);
        set_slots(16'h0005, 16'h0002);
        txq.push_back(rnd());
        wr(cse_pkg::ADDR_TX_DATA, txq[0]);
        chk_status();
        frame(3);
        chk_status();
        chk("irq", {15'h0000, o_irq}, 16'h0001);
        drain();
        idle = 1'b0;
        wr(cse_pkg::ADDR_CTRL, 16'h0001);
        set_slots(16'h003f, 16'h0001);
        frame(6);
        chk_status();
        drain();
        chk_status();
        txq.push_back(rnd());
        wr(cse_pkg::ADDR_TX_DATA, txq[0]);
        unf = 1'b0;
        chk_status();
        rd(cse_pkg::ADDR_IRQ_STAT);
        chk("irq_stat", rd_v, 16'h000f);
        wr(cse_pkg::ADDR_IRQ_EN, 16'h0000);
        rd(cse_pkg::ADDR_IRQ_STAT);
        chk("irq_masked", {15'h0000, o_irq}, 16'h0000);
        wr(cse_pkg::ADDR_IRQ_CLR, 16'h000f);
        rd(cse_pkg::ADDR_IRQ_STAT);
        chk("irq_clr", rd_v, 16'h0000);
        finish_test();
    end
endmodule : tb
